// ==== verilog/ccr_pkg.sv ====
package ccr_pkg;

  // Clock rate and the second, from which every long count is derived.
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned NS_PER_SEC        = 1000000000;
  localparam int unsigned CLK_TICKS_PER_SEC = NS_PER_SEC / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_HOUR      = 3600;

  // Register addresses as seen by the serial-port register access path.
  localparam logic [7:0] CHARGE_VOLTAGE_ADDR = 8'h04;
  localparam logic [7:0] TERM_TIMER_ADDR     = 8'h05;
  localparam logic [7:0] BOOST_THERMAL_ADDR  = 8'h06;

  // Reset values of the three registers.
  localparam logic [7:0] CHARGE_VOLTAGE_RESET = 8'hb2;
  localparam logic [7:0] TERM_TIMER_RESET     = 8'h9c;
  localparam logic [7:0] BOOST_THERMAL_RESET  = 8'h73;

  // Field positions.
  localparam int unsigned CHARGE_CODE_LSB   = 2;
  localparam int unsigned PRE_EXIT_BIT      = 1;
  localparam int unsigned RECHARGE_SEL_BIT  = 0;
  localparam int unsigned TERM_ENABLE_BIT   = 7;
  localparam int unsigned HOST_TIMEOUT_LSB  = 4;
  localparam int unsigned SAFETY_ENABLE_BIT = 3;
  localparam int unsigned DURATION_LSB      = 1;
  localparam int unsigned BOOST_CODE_LSB    = 4;
  localparam int unsigned BOOST_HOT_LSB     = 2;
  localparam int unsigned THERMAL_LIM_LSB   = 0;

  // Voltages in millivolts.
  localparam logic [12:0] CHARGE_BASE_MV    = 13'hdb0;  // 3504 mV
  localparam logic [12:0] CHARGE_MAX_MV     = 13'h1130; // 4400 mV
  localparam int unsigned CHARGE_STEP_SHIFT = 4;        // 16 mV per step
  localparam logic [12:0] PRE_EXIT_LOW_MV   = 13'haf0;  // 2800 mV
  localparam logic [12:0] PRE_EXIT_HIGH_MV  = 13'hbb8;  // 3000 mV
  localparam logic [12:0] RECHARGE_LOW_MV   = 13'h064;  // 100 mV
  localparam logic [12:0] RECHARGE_HIGH_MV  = 13'h12c;  // 300 mV
  localparam logic [12:0] BOOST_BASE_MV     = 13'h11c6; // 4550 mV
  localparam int unsigned BOOST_STEP_SHIFT  = 6;        // 64 mV per step

  // Thermistor thresholds in percent of the internal regulator rail.
  localparam logic [6:0] BOOST_HOT_33_PCT = 7'h21;
  localparam logic [6:0] BOOST_HOT_36_PCT = 7'h24;
  localparam logic [6:0] BOOST_HOT_30_PCT = 7'h1e;
  localparam logic [6:0] BOOST_COLD_PCT   = 7'h4c;

  // Die temperature limits in degrees Celsius.
  localparam logic [7:0] THERMAL_60_C  = 8'h3c;
  localparam logic [7:0] THERMAL_80_C  = 8'h50;
  localparam logic [7:0] THERMAL_100_C = 8'h64;
  localparam logic [7:0] THERMAL_120_C = 8'h78;

  // Timer limits: seconds and hours as printed, then derived seconds.
  localparam int unsigned SEC_W            = 17;
  localparam logic [SEC_W-1:0] HOST_40_S   = 17'h00028;
  localparam logic [SEC_W-1:0] HOST_80_S   = 17'h00050;
  localparam logic [SEC_W-1:0] HOST_160_S  = 17'h000a0;
  localparam int unsigned SAFETY_5_HRS     = 5;
  localparam int unsigned SAFETY_8_HRS     = 8;
  localparam int unsigned SAFETY_12_HRS    = 12;
  localparam int unsigned SAFETY_20_HRS    = 20;
  localparam logic [SEC_W-1:0] SAFETY_5_SEC  = SEC_W'(SAFETY_5_HRS * SEC_PER_HOUR);
  localparam logic [SEC_W-1:0] SAFETY_8_SEC  = SEC_W'(SAFETY_8_HRS * SEC_PER_HOUR);
  localparam logic [SEC_W-1:0] SAFETY_12_SEC = SEC_W'(SAFETY_12_HRS * SEC_PER_HOUR);
  localparam logic [SEC_W-1:0] SAFETY_20_SEC = SEC_W'(SAFETY_20_HRS * SEC_PER_HOUR);

  // Boost hot threshold codes.
  typedef enum logic [1:0] {
    BHOT_33  = 2'b00,
    BHOT_36  = 2'b01,
    BHOT_30  = 2'b10,
    BHOT_OFF = 2'b11
  } ccr_bhot_e;

  // One register access from the serial-port front end.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_access_s;

  // Registered answer to an access.
  typedef struct packed {
    logic       ack;
    logic       error;
    logic [7:0] rdata;
  } ccr_reply_s;

  // Decoded set points handed to the analog and charge control logic.
  typedef struct packed {
    logic [12:0] charge_mv;
    logic [12:0] precharge_exit_mv;
    logic [12:0] recharge_mv;
    logic [12:0] boost_mv;
    logic [7:0]  thermal_limit_c;
    logic        termination_enable;
    logic        safety_enable;
  } ccr_setpoint_s;

endpackage

// ==== verilog/ccr_sec_timer.sv ====
`timescale 1ns/1ps
module ccr_sec_timer #(
  parameter int unsigned TICKS_PER_SEC = ccr_pkg::CLK_TICKS_PER_SEC
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       restart_i,
  input  wire logic [ccr_pkg::SEC_W-1:0]  limit_sec_i,
  output logic                            expired_o
);
  import ccr_pkg::*;

  localparam int unsigned TICK_W = $clog2(TICKS_PER_SEC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICKS_PER_SEC - 1);

  logic [TICK_W-1:0] tick_count;
  logic [SEC_W-1:0]  sec_count;

  // Counts whole seconds; expiry sticks until the next restart, so a late reader still sees it.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_count <= '0;
      sec_count  <= '0;
      expired_o  <= 1'b0;
    end else if (restart_i) begin
      tick_count <= '0;
      sec_count  <= '0;
      expired_o  <= 1'b0;
    end else if (!expired_o) begin
      if (tick_count == TICK_LAST) begin
        tick_count <= '0;
        sec_count  <= sec_count + 1'b1;
        if (sec_count + 1'b1 >= limit_sec_i) begin
          expired_o <= 1'b1;
        end
      end else begin
        tick_count <= tick_count + 1'b1;
      end
    end
  end
endmodule

// ==== verilog/ccr_thermistor_monitor.sv ====
`timescale 1ns/1ps
module ccr_thermistor_monitor (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire ccr_pkg::ccr_bhot_e bhot_code_i,
  input  wire logic [6:0]         thermistor_pct_i,
  input  wire logic               boost_active_i,
  output logic                    boost_hot_cutoff_o,
  output logic                    thermistor_fault_o
);
  import ccr_pkg::*;

  logic [6:0] hot_pct;
  logic       cutoff_enabled;

  // A hotter thermistor gives a lower voltage, so hot means at or below the threshold.
  always_comb begin
    cutoff_enabled = 1'b1;
    unique case (bhot_code_i)
      BHOT_33: hot_pct = BOOST_HOT_33_PCT;
      BHOT_36: hot_pct = BOOST_HOT_36_PCT;
      BHOT_30: hot_pct = BOOST_HOT_30_PCT;
      BHOT_OFF: begin
        hot_pct        = BOOST_HOT_33_PCT;
        cutoff_enabled = 1'b0;
      end
    endcase
  end

  // Both thresholds are fractions of the regulator rail, so no absolute voltage is needed.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boost_hot_cutoff_o <= 1'b0;
      thermistor_fault_o <= 1'b0;
    end else begin
      boost_hot_cutoff_o <= boost_active_i && cutoff_enabled && (thermistor_pct_i <= hot_pct);
      thermistor_fault_o <= boost_active_i && ((thermistor_pct_i <= hot_pct) ||
                                               (thermistor_pct_i >= BOOST_COLD_PCT));
    end
  end
endmodule

// ==== verilog/charger_config_registers.sv ====
`timescale 1ns/1ps
// Operation
// - Charge voltage: 3504 mV plus 16 mV steps
// - Precharge exit threshold: 2.8 V or 3.0 V
// - Recharge offset: 100 mV or 300 mV
// - Termination enable bit gates charge termination
// - Host timeout: off, 40, 80, 160 s
// - Safety timer enable and 5/8/12/20 hour limit
// - Boost voltage: 4550 mV plus 64 mV steps
// - Boost hot threshold: 33, 36, 30 percent
// - Code 11 keeps fault, drops boost cutoff
// - Thermal regulation limit: 60 to 120 C
// - Timer register resets 0x9c, fully read/write
// - Boost register resets 0x73, fully read/write
// - Thermistor thresholds reference regulator rail, cold 76%
module charger_config_registers #(
  parameter int unsigned TICKS_PER_SEC = ccr_pkg::CLK_TICKS_PER_SEC
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire ccr_pkg::ccr_access_s   access_i,
  output ccr_pkg::ccr_reply_s         reply_o,
  input  wire logic                   charging_i,
  input  wire logic                   term_current_reached_i,
  input  wire logic [12:0]            battery_mv_i,
  input  wire logic [7:0]             die_temp_c_i,
  input  wire logic [6:0]             thermistor_pct_i,
  input  wire logic                   boost_active_i,
  output ccr_pkg::ccr_setpoint_s      setpoint_o,
  output logic                        precharge_o,
  output logic                        recharge_o,
  output logic                        terminate_o,
  output logic                        thermal_regulation_o,
  output logic                        boost_hot_cutoff_o,
  output logic                        thermistor_fault_o,
  output logic                        host_absent_o,
  output logic                        safety_expired_o
);
  import ccr_pkg::*;

  logic [7:0]       charge_voltage_control;
  logic [7:0]       termination_timer_control;
  logic [7:0]       boost_thermal_control;
  logic [5:0]       charge_voltage_code;
  logic [3:0]       boost_voltage_code;
  logic [1:0]       host_timeout_select;
  logic [1:0]       fast_charge_duration;
  logic [1:0]       thermal_regulation_limit;
  ccr_bhot_e        boost_hot_code;
  logic [12:0]      next_charge_mv;
  logic [12:0]      next_boost_mv;
  logic [7:0]       next_thermal_limit;
  logic [SEC_W-1:0] host_limit_sec;
  logic [SEC_W-1:0] safety_limit_sec;
  logic             host_access;
  logic             safety_restart;

  // Field views of the stored registers.
  assign charge_voltage_code      = charge_voltage_control[CHARGE_CODE_LSB +: 6];
  assign host_timeout_select      = termination_timer_control[HOST_TIMEOUT_LSB +: 2];
  assign fast_charge_duration     = termination_timer_control[DURATION_LSB +: 2];
  assign boost_voltage_code       = boost_thermal_control[BOOST_CODE_LSB +: 4];
  assign thermal_regulation_limit = boost_thermal_control[THERMAL_LIM_LSB +: 2];
  assign boost_hot_code           = ccr_bhot_e'(boost_thermal_control[BOOST_HOT_LSB +: 2]);
  assign host_access              = access_i.valid;

  // Register writes; every bit is stored, reserved ones included, so reads return what was written.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      charge_voltage_control    <= CHARGE_VOLTAGE_RESET;
      termination_timer_control <= TERM_TIMER_RESET;
      boost_thermal_control     <= BOOST_THERMAL_RESET;
    end else if (access_i.valid && access_i.write) begin
      unique case (access_i.addr)
        CHARGE_VOLTAGE_ADDR: charge_voltage_control    <= access_i.wdata;
        TERM_TIMER_ADDR:     termination_timer_control <= access_i.wdata;
        BOOST_THERMAL_ADDR:  boost_thermal_control     <= access_i.wdata;
        default: ;
      endcase
    end
  end

  // Registered answer one cycle after the access; unmapped addresses read zero and flag an error.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reply_o <= '0;
    end else begin
      reply_o.ack   <= access_i.valid;
      reply_o.error <= 1'b0;
      reply_o.rdata <= 8'h00;
      if (access_i.valid) begin
        unique case (access_i.addr)
          CHARGE_VOLTAGE_ADDR: reply_o.rdata <= access_i.write ? 8'h00 : charge_voltage_control;
          TERM_TIMER_ADDR:     reply_o.rdata <= access_i.write ? 8'h00 : termination_timer_control;
          BOOST_THERMAL_ADDR:  reply_o.rdata <= access_i.write ? 8'h00 : boost_thermal_control;
          default:             reply_o.error <= 1'b1;
        endcase
      end
    end
  end

  // Voltage arithmetic; charge codes past the top of the span are held at the ceiling rather than overshooting.
  always_comb begin
    next_charge_mv = CHARGE_BASE_MV + {3'h0, charge_voltage_code, 4'h0};
    if (next_charge_mv > CHARGE_MAX_MV) begin
      next_charge_mv = CHARGE_MAX_MV;
    end
    next_boost_mv = BOOST_BASE_MV + {3'h0, boost_voltage_code, 6'h00};
  end

  // Thermal regulation start temperature.
  always_comb begin
    unique case (thermal_regulation_limit)
      2'b00: next_thermal_limit = THERMAL_60_C;
      2'b01: next_thermal_limit = THERMAL_80_C;
      2'b10: next_thermal_limit = THERMAL_100_C;
      2'b11: next_thermal_limit = THERMAL_120_C;
    endcase
  end

  // Timer limits; the host limit of code 00 never matters because the timer is then held in restart.
  always_comb begin
    unique case (host_timeout_select)
      2'b00: host_limit_sec = HOST_40_S;
      2'b01: host_limit_sec = HOST_40_S;
      2'b10: host_limit_sec = HOST_80_S;
      2'b11: host_limit_sec = HOST_160_S;
    endcase
    unique case (fast_charge_duration)
      2'b00: safety_limit_sec = SAFETY_5_SEC;
      2'b01: safety_limit_sec = SAFETY_8_SEC;
      2'b10: safety_limit_sec = SAFETY_12_SEC;
      2'b11: safety_limit_sec = SAFETY_20_SEC;
    endcase
  end

  // Set points are registered so the analog side sees glitch-free values.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setpoint_o <= '0;
    end else begin
      setpoint_o.charge_mv          <= next_charge_mv;
      setpoint_o.precharge_exit_mv  <= charge_voltage_control[PRE_EXIT_BIT] ?
                                       PRE_EXIT_HIGH_MV : PRE_EXIT_LOW_MV;
      setpoint_o.recharge_mv        <= next_charge_mv - (charge_voltage_control[RECHARGE_SEL_BIT] ?
                                       RECHARGE_HIGH_MV : RECHARGE_LOW_MV);
      setpoint_o.boost_mv           <= next_boost_mv;
      setpoint_o.thermal_limit_c    <= next_thermal_limit;
      setpoint_o.termination_enable <= termination_timer_control[TERM_ENABLE_BIT];
      setpoint_o.safety_enable      <= termination_timer_control[SAFETY_ENABLE_BIT];
    end
  end

  // Precharge, recharge and thermal decisions use the registered set points, one cycle behind a register write; termination reads the enable bit directly.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      precharge_o          <= 1'b0;
      recharge_o           <= 1'b0;
      terminate_o          <= 1'b0;
      thermal_regulation_o <= 1'b0;
    end else begin
      precharge_o          <= battery_mv_i < setpoint_o.precharge_exit_mv;
      recharge_o           <= battery_mv_i < setpoint_o.recharge_mv;
      terminate_o          <= term_current_reached_i &&
                              termination_timer_control[TERM_ENABLE_BIT];
      thermal_regulation_o <= die_temp_c_i >= setpoint_o.thermal_limit_c;
    end
  end

  // Any host access restarts the watchdog; with the timeout off it is held in restart.
  ccr_sec_timer #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_host_watchdog (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .restart_i   (host_access || (host_timeout_select == 2'b00)),
    .limit_sec_i (host_limit_sec),
    .expired_o   (host_absent_o)
  );

  // The safety timer runs only while enabled and charging; leaving either state clears it.
  assign safety_restart = !(termination_timer_control[SAFETY_ENABLE_BIT] && charging_i);

  ccr_sec_timer #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_safety_timer (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .restart_i   (safety_restart),
    .limit_sec_i (safety_limit_sec),
    .expired_o   (safety_expired_o)
  );

  // Boost temperature monitor against rail-relative thresholds.
  ccr_thermistor_monitor u_thermistor (
    .clk_i              (clk_i),
    .reset_n_i          (reset_n_i),
    .bhot_code_i        (boost_hot_code),
    .thermistor_pct_i   (thermistor_pct_i),
    .boost_active_i     (boost_active_i),
    .boost_hot_cutoff_o (boost_hot_cutoff_o),
    .thermistor_fault_o (thermistor_fault_o)
  );

  // Checks on the block's own outputs.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_charge_write;
    (access_i.valid && access_i.write && access_i.addr == CHARGE_VOLTAGE_ADDR) |=> ##1
    setpoint_o.charge_mv == ((CHARGE_BASE_MV + {3'h0, $past(access_i.wdata[7:2], 2), 4'h0} > CHARGE_MAX_MV) ?
                             CHARGE_MAX_MV : CHARGE_BASE_MV + {3'h0, $past(access_i.wdata[7:2], 2), 4'h0});
  endproperty
  a_charge_write: assert property (p_charge_write) else $error("charge voltage set point wrong");

  property p_charge_ceiling;
    setpoint_o.charge_mv <= CHARGE_MAX_MV;
  endproperty
  a_charge_ceiling: assert property (p_charge_ceiling) else $error("charge voltage above ceiling");

  property p_pre_exit;
    1'b1 |=> setpoint_o.precharge_exit_mv ==
             ($past(charge_voltage_control[PRE_EXIT_BIT]) ? 13'hbb8 : 13'haf0);
  endproperty
  a_pre_exit: assert property (p_pre_exit) else $error("precharge exit threshold wrong");

  property p_recharge_gap;
    1'b1 |=> setpoint_o.charge_mv - setpoint_o.recharge_mv ==
             ($past(charge_voltage_control[RECHARGE_SEL_BIT]) ? 13'h12c : 13'h064);
  endproperty
  a_recharge_gap: assert property (p_recharge_gap) else $error("recharge offset wrong");

  property p_term_blocked;
    !termination_timer_control[TERM_ENABLE_BIT] |=> !terminate_o;
  endproperty
  a_term_blocked: assert property (p_term_blocked) else $error("termination while disabled");

  property p_watchdog_off;
    $rose(host_absent_o) |-> $past(host_timeout_select) != 2'b00 && !$past(host_access);
  endproperty
  a_watchdog_off: assert property (p_watchdog_off) else $error("host timeout with watchdog off");

  property p_safety_off;
    !termination_timer_control[SAFETY_ENABLE_BIT] |=> !safety_expired_o;
  endproperty
  a_safety_off: assert property (p_safety_off) else $error("safety expiry while disabled");

  property p_boost_write;
    (access_i.valid && access_i.write && access_i.addr == BOOST_THERMAL_ADDR &&
     access_i.wdata[7:4] == 4'hf) |=> ##1 setpoint_o.boost_mv == 13'h1586;
  endproperty
  a_boost_write: assert property (p_boost_write) else $error("boost voltage set point wrong");

  property p_hot_off;
    boost_hot_code == BHOT_OFF |=> !boost_hot_cutoff_o;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("boost cutoff with monitor off");

  property p_hot_off_fault;
    (boost_hot_code == BHOT_OFF && boost_active_i && thermistor_pct_i <= 7'h21) |=> thermistor_fault_o;
  endproperty
  a_hot_off_fault: assert property (p_hot_off_fault) else $error("thermistor fault missing");

  property p_thermal;
    (die_temp_c_i >= setpoint_o.thermal_limit_c) |=> thermal_regulation_o;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal regulation not entered");

  property p_timer_readback;
    (access_i.valid && access_i.write && access_i.addr == TERM_TIMER_ADDR) ##1
    (access_i.valid && !access_i.write && access_i.addr == TERM_TIMER_ADDR)
    |=> reply_o.ack && reply_o.rdata == $past(access_i.wdata, 2);
  endproperty
  a_timer_readback: assert property (p_timer_readback) else $error("timer register readback wrong");

  property p_boost_readback;
    (access_i.valid && access_i.write && access_i.addr == BOOST_THERMAL_ADDR) ##1
    (access_i.valid && !access_i.write && access_i.addr == BOOST_THERMAL_ADDR)
    |=> reply_o.ack && reply_o.rdata == $past(access_i.wdata, 2);
  endproperty
  a_boost_readback: assert property (p_boost_readback) else $error("boost register readback wrong");

  property p_cold_fault;
    (boost_active_i && thermistor_pct_i >= 7'h4c) |=> thermistor_fault_o;
  endproperty
  a_cold_fault: assert property (p_cold_fault) else $error("cold fault missing");

  c_host_absent: cover property ($rose(host_absent_o));
  c_safety_expired: cover property ($rose(safety_expired_o));
  c_unmapped: cover property (reply_o.ack && reply_o.error);
  c_hot_cutoff: cover property ($rose(boost_hot_cutoff_o));

endmodule

// ==== verif/ccr_host_model.sv ====
`timescale 1ns/1ps
module ccr_host_model (
  input  wire logic                clk_i,
  output ccr_pkg::ccr_access_s     access_o,
  input  wire ccr_pkg::ccr_reply_s reply_i
);
  import ccr_pkg::*;
  // The port starts idle, so nothing is taken before the first call.
  initial begin
    access_o = '0;
  end
  // One access is launched after an edge and taken at the next one; the answer is taken one edge later.
  // Released fields carry the inverse pattern so that a stale value is never mistaken for a request.
  // Every call restarts the host timeout, so callers keep accesses closer than the limit when needed.
  // With back set, a read of the same address follows in the very next cycle.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, input logic back,
                      output ccr_reply_s rep);
    @(posedge clk_i);
    #1;
    access_o = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
    @(posedge clk_i);
    #1;
    if (back) begin
      access_o.write = 1'b0;
      @(posedge clk_i);
      #1;
    end
    access_o = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
    @(posedge clk_i);
    rep = reply_i;
  endtask
endmodule

// ==== verif/charger_config_registers_bench.sv ====
`timescale 1ns/1ps
module charger_config_registers_bench;
  import ccr_pkg::*;
  localparam int unsigned TPS = 4;
  logic          clk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  ccr_access_s   acc_s;
  ccr_reply_s    rep_s;
  ccr_reply_s    rep;
  ccr_setpoint_s sp;
  logic          chg = 1'b0;
  logic          term_hit = 1'b0;
  logic          boost_on = 1'b0;
  logic [12:0]   batt = 13'h0fa0;
  logic [7:0]    die = 8'h19;
  logic [6:0]    pct = 7'h32;
  logic          pre_o, rech_o, term_o, thermal_regulation_limit_o, cut_o, flt_o, absent_o, safe_o;
  int            mismatches = 0;
  int            n_compared = 0;
  logic [7:0]    tlim [4] = '{8'h3c, 8'h50, 8'h64, 8'h78};
  logic [6:0]    thot [4] = '{7'h21, 7'h24, 7'h1e, 7'h21};
  logic [5:0]    ccode [3] = '{6'h00, 6'h38, 6'h3f};
  // Free-running 250 MHz clock.
  always #2 clk_i = ~clk_i;
  charger_config_registers #(.TICKS_PER_SEC(TPS)) charger_config_registers_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .access_i(acc_s), .reply_o(rep_s), .charging_i(chg),
    .term_current_reached_i(term_hit), .battery_mv_i(batt), .die_temp_c_i(die), .thermistor_pct_i(pct),
    .boost_active_i(boost_on), .setpoint_o(sp), .precharge_o(pre_o), .recharge_o(rech_o),
    .terminate_o(term_o), .thermal_regulation_o(thermal_regulation_limit_o), .boost_hot_cutoff_o(cut_o),
    .thermistor_fault_o(flt_o), .host_absent_o(absent_o), .safety_expired_o(safe_o));
  ccr_host_model ccr_host_model_inst (.clk_i(clk_i), .access_o(acc_s), .reply_i(rep_s));
  // Compare helpers; cycles() leaves time 1 ns past an edge so outputs have settled.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    ccr_host_model_inst.xfer(wr, a, d, 1'b0, rep);
    chk("ack", 16'h0001, {15'h0, rep.ack});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    cycles(3);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic err);
    acc(1'b0, a, 8'h00);
    chk("rdata", {8'h0, exp}, {8'h0, rep.rdata});
    chk("error", {15'h0, err}, {15'h0, rep.error});
  endtask
  // Reset values of the registers and of the decoded set points, plus an unmapped read.
  task automatic t_reset();
    rd(CHARGE_VOLTAGE_ADDR, 8'hb2, 1'b0);
    rd(TERM_TIMER_ADDR, 8'h9c, 1'b0);
    rd(BOOST_THERMAL_ADDR, 8'h73, 1'b0);
    rd(8'h07, 8'h00, 1'b1);
    chk("charge_mv", 16'h1070, 16'(sp.charge_mv));
    chk("pre_exit", 16'h0bb8, 16'(sp.precharge_exit_mv));
    chk("recharge", 16'h100c, 16'(sp.recharge_mv));
    chk("boost_mv", 16'h1386, 16'(sp.boost_mv));
    chk("thermal", 16'h0078, 16'(sp.thermal_limit_c));
    chk("term_en", 16'h0001, 16'(sp.termination_enable));
    chk("safety_en", 16'h0001, 16'(sp.safety_enable));
    $display("t_reset done");
  endtask
  // Every timer and boost register bit, reserved ones too, reads back; an unmapped write is refused and harmless.
  task automatic t_rw();
    wr(TERM_TIMER_ADDR, 8'h5a);
    rd(TERM_TIMER_ADDR, 8'h5a, 1'b0);
    wr(BOOST_THERMAL_ADDR, 8'ha5);
    rd(BOOST_THERMAL_ADDR, 8'ha5, 1'b0);
    ccr_host_model_inst.xfer(1'b1, TERM_TIMER_ADDR, 8'h63, 1'b1, rep);
    chk("b2b timer", 16'h0163, {7'h0, rep.ack, rep.rdata});
    ccr_host_model_inst.xfer(1'b1, BOOST_THERMAL_ADDR, 8'h3c, 1'b1, rep);
    chk("b2b boost", 16'h013c, {7'h0, rep.ack, rep.rdata});
    acc(1'b1, 8'h03, 8'hff);
    chk("wr error", 16'h0001, {15'h0, rep.error});
    rd(CHARGE_VOLTAGE_ADDR, 8'hb2, 1'b0);
    wr(TERM_TIMER_ADDR, 8'h9c);
    $display("t_rw done");
  endtask
  // Charge code at the floor, at the top of the span and above it, with both threshold bits.
  task automatic t_charge();
    logic [12:0] e;
    batt = 13'h0b54;
    for (int i = 0; i < 3; i++) begin
      wr(CHARGE_VOLTAGE_ADDR, {ccode[i], i[0], i[1]});
      e = CHARGE_BASE_MV + (13'(ccode[i]) << CHARGE_STEP_SHIFT);
      if (e > CHARGE_MAX_MV) e = CHARGE_MAX_MV;
      chk("charge_mv", 16'(e), 16'(sp.charge_mv));
      chk("pre_exit", 16'(i[0] ? PRE_EXIT_HIGH_MV : PRE_EXIT_LOW_MV), 16'(sp.precharge_exit_mv));
      chk("precharge", 16'(i[0]), 16'(pre_o));
      chk("recharge", 16'(e - (i[1] ? RECHARGE_HIGH_MV : RECHARGE_LOW_MV)), 16'(sp.recharge_mv));
    end
    batt = 13'h1004;
    cycles(2);
    chk("recharge_o at", 16'h0000, 16'(rech_o));
    batt = 13'h1003;
    cycles(2);
    chk("recharge_o below", 16'h0001, 16'(rech_o));
    $display("t_charge done");
  endtask
  // Boost codes across the span and every thermal limit, probed at and just below the limit.
  task automatic t_boost();
    for (int k = 0; k < 4; k++) begin
      wr(BOOST_THERMAL_ADDR, {4'(k * 5), 2'b00, 2'(k)});
      chk("boost_mv", 16'(BOOST_BASE_MV + 13'(k * 5 * 64)), 16'(sp.boost_mv));
      chk("thermal", 16'(tlim[k]), 16'(sp.thermal_limit_c));
      die = tlim[k];
      cycles(2);
      chk("thermal_regulation_limit at", 16'h0001, 16'(thermal_regulation_limit_o));
      die = tlim[k] - 8'h01;
      cycles(2);
      chk("thermal_regulation_limit below", 16'h0000, 16'(thermal_regulation_limit_o));
    end
    $display("t_boost done");
  endtask
  // Every hot code at and just past its threshold; code 11 keeps the fault but not the cutoff.
  task automatic t_bhot();
    boost_on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(BOOST_THERMAL_ADDR, {4'h7, 2'(k), 2'b11});
      pct = thot[k];
      cycles(2);
      chk("cutoff", 16'(k != 3), 16'(cut_o));
      chk("fault", 16'h0001, 16'(flt_o));
      pct = thot[k] + 7'h01;
      cycles(2);
      chk("cutoff off", 16'h0000, 16'(cut_o));
      chk("fault off", 16'h0000, 16'(flt_o));
    end
    pct = BOOST_COLD_PCT;
    cycles(2);
    chk("cold", 16'h0001, 16'(flt_o));
    boost_on = 1'b0;
    $display("t_bhot done");
  endtask
  // Termination follows the enable bit; then the 40 s and 80 s host timeouts and the disable code.
  task automatic t_timers();
    term_hit = 1'b1;
    wr(TERM_TIMER_ADDR, 8'h1c);
    chk("term off", 16'h0000, 16'(term_o));
    wr(TERM_TIMER_ADDR, 8'h9c);
    chk("term on", 16'h0001, 16'(term_o));
    cycles(155);
    chk("absent early", 16'h0000, 16'(absent_o));
    cycles(2);
    chk("absent", 16'h0001, 16'(absent_o));
    wr(TERM_TIMER_ADDR, 8'hac);
    cycles(315);
    chk("absent 80 early", 16'h0000, 16'(absent_o));
    cycles(2);
    chk("absent 80", 16'h0001, 16'(absent_o));
    wr(TERM_TIMER_ADDR, 8'h8c);
    cycles(200);
    chk("absent off", 16'h0000, 16'(absent_o));
    $display("t_timers done");
  endtask
  // Five-hour safety limit, then the flag clears when charging stops.
  task automatic t_safety();
    wr(TERM_TIMER_ADDR, 8'h88);
    chg = 1'b1;
    cycles(71990);
    chk("safety early", 16'h0000, 16'(safe_o));
    cycles(20);
    chk("safety", 16'h0001, 16'(safe_o));
    chg = 1'b0;
    cycles(2);
    chk("safety clear", 16'h0000, 16'(safe_o));
    $display("t_safety done");
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence after ten cycles of reset.
  initial begin
    cycles(10);
    reset_n_i = 1'b1;
    t_reset();
    t_rw();
    t_charge();
    t_boost();
    t_bhot();
    t_timers();
    t_safety();
    report_and_stop();
  end
  // The tests need about 300 us; a hang is cut off well after that.
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule
